/* File: logic/drc_defines.vh */
// register map, field positions, encodings and reset values of the request and end control channel
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH
`define DRC_OFF_MODE 8'h00
`define DRC_OFF_ACR 8'h04
`define DRC_OFF_CNT 8'h08
`define DRC_OFF_BLK 8'h0C
`define DRC_MD_EN 0
`define DRC_MD_BUSY 1
`define DRC_MD_CEF 2
`define DRC_MD_ESF 3
`define DRC_MD_CEIE 4
`define DRC_MD_SZ_ERR_IE 5
`define DRC_MD_NEXT_DLY 6
`define DRC_MD_EXTREQ 7
`define DRC_MD_MODE_LO 8
`define DRC_MD_ASZ_LO 10
`define DRC_MD_DUAL 12
`define DRC_MD_GERR 15
`define DRC_AC_RPT_IE 0
`define DRC_AC_SRC_OVF_IE 1
`define DRC_AC_DST_OVF_IE 2
`define DRC_AC_EAREA 3
`define DRC_MODE_NORMAL 2'h0
`define DRC_MODE_REPEAT 2'h1
`define DRC_MODE_BLOCK 2'h2
`define DRC_ASZ_BYTE 2'h0
`define DRC_ASZ_WORD 2'h1
`define DRC_ASZ_LONG 2'h2
`define DRC_MODE_RST 32'h00000000
`define DRC_ACR_RST 32'h00000000
`define DRC_CNT_RST 32'h00000000
`define DRC_BLK_RST 16'h0001
`define DRC_RESP_OKAY 2'h0
`define DRC_RESP_SLVERR 2'h2
`define DRC_NEXT_DLY_CYCLES 1
`endif

/* File: logic/drc_sync2.v */
// two flip-flop synchroniser for the external request pin
`timescale 1ns/1ns
module drc_sync2 (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // async level in, synchronised level out
  input wire async_i,
  output wire sync_o
);
  reg meta_reg;
  reg sync_reg;
  // idle level is high so no false request at reset
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end
  assign sync_o = sync_reg;
endmodule

/* File: logic/drc_channel.v */
// dma channel: external request acceptance, transfer unit sequencing and end conditions, axi4-lite registers
`timescale 1ns/1ns
`include "drc_defines.vh"
//
// Contract
// - sample request every idle cycle after enable write
// - latch low request, clear when served
// - accept next request after unit completes
// - next request delay adds one cycle
// - end clears enable and busy
// - count reaching zero ends, sets count flag
// - count zero at start is never short, count wraps
// - short count with size error enabled escapes
// - block mode compares count to block size
// - size error off: remainder moved bytewise
// - block remainder moved as bytes
// - repeat end escapes, enable resumes
// - block end may raise repeat end
// - area overflow escapes when enabled
// - dual mode finishes write after overflow
// - block finishes before overflow stop
// - software clear finishes accepted work
// - nmi clears enable, sets error, stops
// - address error acts like nmi
// - forced stop finishes current unit
// - block forced stop ends after write
module drc_channel (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // axi4-lite read
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // external request pin
  input wire dma_request_in_n_i,
  // system events, same clock
  input wire nmi_i,
  input wire addr_error_i,
  input wire src_overflow_i,
  input wire dst_overflow_i,
  // bus cycle handshake toward the bus controller
  output wire cyc_req_o,
  output wire cyc_write_o,
  output wire [2:0] cyc_bytes_o,
  input wire cyc_done_i,
  // status
  output wire count_end_irq_o,
  output wire escape_end_irq_o
);
  localparam S_IDLE = 5'b00001;
  localparam S_RD = 5'b00010;
  localparam S_WR = 5'b00100;
  localparam S_SGL = 5'b01000;
  localparam S_GAP = 5'b10000;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function [2:0] unit_bytes;
    input [1:0] asz;
    begin
      case (asz)
        `DRC_ASZ_WORD: unit_bytes = 3'h2;
        `DRC_ASZ_LONG: unit_bytes = 3'h4;
        default: unit_bytes = 3'h1;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg aw_ok_reg;
  reg [7:0] awaddr_reg;
  reg w_ok_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg en_reg;
  reg en_next;
  reg busy_reg;
  reg ce_reg;
  reg ce_next;
  reg es_reg;
  reg es_next;
  reg gerr_reg;
  reg gerr_next;
  reg ceie_reg;
  reg szie_reg;
  reg next_dly_reg;
  reg ext_reg;
  reg [1:0] mode_reg;
  reg [1:0] asz_reg;
  reg dual_reg;
  reg rpt_ie_reg;
  reg src_ovf_ie_reg;
  reg dst_ovf_ie_reg;
  reg earea_reg;
  reg [31:0] cnt_reg;
  reg [31:0] cnt_next;
  reg [15:0] blk_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg pend_reg;
  reg pend_next;
  reg samp_en_reg;
  reg stop_reg;
  reg stop_next;
  reg ovf_reg;
  reg ovf_next;
  reg [18:0] blk_left_reg;
  reg [18:0] blk_left_next;
  reg [2:0] bytes_reg;
  reg [2:0] bytes_next;
  reg [15:0] rpt_cnt_reg;
  reg [15:0] rpt_cnt_next;
  reg rpt_done_reg;
  reg rpt_done_next;
  reg end_now;
  reg short_cnt;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire req_n_s;
  wire do_wr;
  wire wr_mode;
  wire wr_acr;
  wire wr_cnt;
  wire wr_blk;
  wire [31:0] mode_rd;
  wire [31:0] acr_rd;
  wire [31:0] mw;
  wire [31:0] aw;
  wire [31:0] cw;
  wire [31:0] bw;
  wire [2:0] ub;
  wire [18:0] blk_bytes;
  wire is_block;

  ////////////////////////////////////////////////////////////////////////////
  // request pin synchroniser

  drc_sync2 u_req_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(dma_request_in_n_i),
    .sync_o(req_n_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  assign s_axi_awready_o = !aw_ok_reg;
  assign s_axi_wready_o = !w_ok_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign do_wr = aw_ok_reg && w_ok_reg && !bvalid_reg;
  assign wr_mode = do_wr && (awaddr_reg == `DRC_OFF_MODE);
  assign wr_acr = do_wr && (awaddr_reg == `DRC_OFF_ACR);
  assign wr_cnt = do_wr && (awaddr_reg == `DRC_OFF_CNT);
  assign wr_blk = do_wr && (awaddr_reg == `DRC_OFF_BLK);

  assign mode_rd = {16'h0000, gerr_reg, 2'h0, dual_reg, asz_reg, mode_reg, ext_reg, next_dly_reg, szie_reg,
                    ceie_reg, es_reg, ce_reg, busy_reg, en_reg};
  assign acr_rd = {28'h0000000, earea_reg, dst_ovf_ie_reg, src_ovf_ie_reg, rpt_ie_reg};
  assign mw = merge(mode_rd, wdata_reg, wstrb_reg);
  assign aw = merge(acr_rd, wdata_reg, wstrb_reg);
  assign cw = merge(cnt_reg, wdata_reg, wstrb_reg);
  assign bw = merge({16'h0000, blk_reg}, wdata_reg, wstrb_reg);

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      `DRC_OFF_MODE: rd_mux = mode_rd;
      `DRC_OFF_ACR: rd_mux = acr_rd;
      `DRC_OFF_CNT: rd_mux = cnt_reg;
      `DRC_OFF_BLK: rd_mux = {16'h0000, blk_reg};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // address and data taken in either order; response once both are held
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_ok_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_ok_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DRC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `DRC_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      if (s_axi_awvalid_i && !aw_ok_reg) begin
        aw_ok_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
      end
      if (s_axi_wvalid_i && !w_ok_reg) begin
        w_ok_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_mode || wr_acr || wr_cnt || wr_blk) ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_arvalid_i && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel engine

  assign ub = unit_bytes(asz_reg);
  assign blk_bytes = {3'h0, blk_reg} * {16'h0000, ub};
  assign is_block = (mode_reg == `DRC_MODE_BLOCK);

  always @* begin
    state_next = state_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    en_next = en_reg;
    ce_next = ce_reg;
    es_next = es_reg;
    gerr_next = gerr_reg;
    stop_next = stop_reg;
    ovf_next = ovf_reg;
    blk_left_next = blk_left_reg;
    bytes_next = bytes_reg;
    rpt_cnt_next = rpt_cnt_reg;
    rpt_done_next = rpt_done_reg;
    end_now = 1'b0;
    // zero count at start means endless, never short
    short_cnt = (cnt_reg != 32'h00000000) &&
                (is_block ? (cnt_reg < {13'h0000, blk_bytes}) : (cnt_reg < {29'h00000000, ub}));
    // software side first so hardware sets override a clear in the same cycle
    if (wr_mode) begin
      if (mw[`DRC_MD_EN] && !gerr_reg) begin
        en_next = 1'b1;
        rpt_done_next = 1'b0;
      end else if (!mw[`DRC_MD_EN]) begin
        en_next = 1'b0;
      end
      if (!mw[`DRC_MD_CEF])
        ce_next = 1'b0;
      if (!mw[`DRC_MD_ESF])
        es_next = 1'b0;
      if (!mw[`DRC_MD_GERR])
        gerr_next = 1'b0;
    end
    if (wr_cnt)
      cnt_next = cw;
    if (samp_en_reg && en_reg && ext_reg && !req_n_s && (state_reg == S_IDLE) && !pend_reg)
      pend_next = 1'b1;
    if (earea_reg && ((src_ovf_ie_reg && src_overflow_i) || (dst_ovf_ie_reg && dst_overflow_i)))
      ovf_next = 1'b1;
    case (state_reg)
      S_IDLE: begin
        if (pend_reg) begin
          pend_next = 1'b0;
          if (rpt_done_reg && rpt_ie_reg && (mode_reg != `DRC_MODE_NORMAL)) begin
            es_next = 1'b1;
            rpt_done_next = 1'b0;
            end_now = 1'b1;
          end else if (short_cnt && szie_reg) begin
            es_next = 1'b1;
            end_now = 1'b1;
          end else begin
            state_next = dual_reg ? S_RD : S_SGL;
            bytes_next = short_cnt ? 3'h1 : ub;
            if (is_block)
              blk_left_next = short_cnt ? cnt_reg[18:0] : {3'h0, blk_reg};
            else
              blk_left_next = 19'h00001;
          end
        end
      end
      S_RD: begin
        // write always follows its read, even on overflow or forced stop
        if (cyc_done_i)
          state_next = S_WR;
      end
      S_WR, S_SGL: begin
        if (cyc_done_i) begin
          cnt_next = cnt_reg - {29'h00000000, bytes_reg};
          if ((cnt_reg != 32'h00000000) && (cnt_reg == {29'h00000000, bytes_reg})) begin
            ce_next = 1'b1;
            end_now = 1'b1;
          end else if (stop_reg) begin
            end_now = 1'b1;
          end else if (blk_left_reg > 19'h00001) begin
            blk_left_next = blk_left_reg - 19'h00001;
            state_next = dual_reg ? S_RD : S_SGL;
          end else if (ovf_reg) begin
            es_next = 1'b1;
            end_now = 1'b1;
          end else begin
            if (is_block) begin
              rpt_done_next = 1'b1;
            end else if (mode_reg == `DRC_MODE_REPEAT) begin
              if (rpt_cnt_reg + 16'h0001 >= blk_reg) begin
                rpt_done_next = 1'b1;
                rpt_cnt_next = 16'h0000;
              end else begin
                rpt_cnt_next = rpt_cnt_reg + 16'h0001;
              end
            end
            state_next = next_dly_reg ? S_GAP : S_IDLE;
          end
        end
      end
      S_GAP: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
    if (end_now) begin
      en_next = 1'b0;
      pend_next = 1'b0;
      stop_next = 1'b0;
      ovf_next = 1'b0;
      state_next = S_IDLE;
    end
    if (nmi_i || addr_error_i) begin
      en_next = 1'b0;
      gerr_next = 1'b1;
      pend_next = 1'b0;
      stop_next = (state_next == S_RD) || (state_next == S_WR) || (state_next == S_SGL);
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= S_IDLE;
      pend_reg <= 1'b0;
      samp_en_reg <= 1'b0;
      en_reg <= 1'b0;
      busy_reg <= 1'b0;
      ce_reg <= 1'b0;
      es_reg <= 1'b0;
      gerr_reg <= 1'b0;
      stop_reg <= 1'b0;
      ovf_reg <= 1'b0;
      cnt_reg <= `DRC_CNT_RST;
      blk_left_reg <= 19'h00000;
      bytes_reg <= 3'h1;
      rpt_cnt_reg <= 16'h0000;
      rpt_done_reg <= 1'b0;
      ceie_reg <= 1'b0;
      szie_reg <= 1'b0;
      next_dly_reg <= 1'b0;
      ext_reg <= 1'b0;
      mode_reg <= `DRC_MODE_NORMAL;
      asz_reg <= `DRC_ASZ_BYTE;
      dual_reg <= 1'b0;
      rpt_ie_reg <= 1'b0;
      src_ovf_ie_reg <= 1'b0;
      dst_ovf_ie_reg <= 1'b0;
      earea_reg <= 1'b0;
      blk_reg <= `DRC_BLK_RST;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      // sampling opens one edge after the enable lands
      samp_en_reg <= en_reg;
      en_reg <= en_next;
      busy_reg <= en_next || pend_next || (state_next != S_IDLE);
      ce_reg <= ce_next;
      es_reg <= es_next;
      gerr_reg <= gerr_next;
      stop_reg <= stop_next;
      ovf_reg <= ovf_next;
      cnt_reg <= cnt_next;
      blk_left_reg <= blk_left_next;
      bytes_reg <= bytes_next;
      rpt_cnt_reg <= rpt_cnt_next;
      rpt_done_reg <= rpt_done_next;
      if (wr_mode) begin
        ceie_reg <= mw[`DRC_MD_CEIE];
        szie_reg <= mw[`DRC_MD_SZ_ERR_IE];
        next_dly_reg <= mw[`DRC_MD_NEXT_DLY];
        ext_reg <= mw[`DRC_MD_EXTREQ];
        mode_reg <= mw[`DRC_MD_MODE_LO +: 2];
        asz_reg <= mw[`DRC_MD_ASZ_LO +: 2];
        dual_reg <= mw[`DRC_MD_DUAL];
      end
      if (wr_acr) begin
        rpt_ie_reg <= aw[`DRC_AC_RPT_IE];
        src_ovf_ie_reg <= aw[`DRC_AC_SRC_OVF_IE];
        dst_ovf_ie_reg <= aw[`DRC_AC_DST_OVF_IE];
        earea_reg <= aw[`DRC_AC_EAREA];
      end
      if (wr_blk)
        blk_reg <= bw[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign cyc_req_o = (state_reg == S_RD) || (state_reg == S_WR) || (state_reg == S_SGL);
  assign cyc_write_o = (state_reg == S_WR);
  assign cyc_bytes_o = bytes_reg;
  assign count_end_irq_o = ce_reg && ceie_reg;
  // escape flag is only ever set by an enabled source
  assign escape_end_irq_o = es_reg;
endmodule

/* File: verif/drc_channel_props.sv */
// concurrent checks on the request and end control channel ports
`timescale 1ns/1ns
module drc_channel_props (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // register bus
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // events and bus cycles
  input wire nmi_i,
  input wire addr_error_i,
  input wire cyc_req_o,
  input wire cyc_write_o,
  input wire [2:0] cyc_bytes_o,
  input wire cyc_done_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> ##1 s_axi_bvalid_o) else $error("write answer late");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  read_ready_a: assert property (s_axi_arready_o == !s_axi_rvalid_o) else $error("read ready wrong");
  unit_hold_a: assert property (cyc_req_o && !cyc_done_i |=> cyc_req_o)
    else $error("bus cycle abandoned");
  unit_size_a: assert property (cyc_req_o && !cyc_done_i |=> $stable(cyc_bytes_o))
    else $error("unit size changed");
  size_legal_a: assert property (cyc_req_o |-> cyc_bytes_o inside {3'h1, 3'h2, 3'h4})
    else $error("unit size illegal");
  nmi_stop_a: assert property (nmi_i ##1 !cyc_req_o [*2] |=> !cyc_req_o [*8])
    else $error("transfer after nmi");
  aerr_stop_a: assert property (addr_error_i ##1 !cyc_req_o [*2] |=> !cyc_req_o [*8])
    else $error("transfer after address error");
  write_phase_a: assert property ($rose(cyc_write_o) |-> $past(cyc_done_i))
    else $error("write phase without read");
endmodule

/* File: verif/drc_periph_model.sv */
// requesting peripheral and bus cycle responder with random latency
`timescale 1ns/1ns
module drc_periph_model (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // control from bench
  input wire want_i,
  input wire [1:0] lat_i,
  // channel side
  input wire cyc_req_i,
  input wire [2:0] cyc_bytes_i,
  output wire req_n_o,
  output reg done_o,
  // observation
  output reg [15:0] units_o,
  output reg [2:0] last_bytes_o,
  output reg [7:0] last_gap_o
);
  reg [1:0] wait_reg;
  reg [7:0] gap_reg;
  reg req_d_reg;
  // level request held while data is wanted
  assign req_n_o = !want_i;
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      units_o <= 16'h0000;
      last_bytes_o <= 3'h0;
      last_gap_o <= 8'h00;
      wait_reg <= 2'h0;
      gap_reg <= 8'h00;
      req_d_reg <= 1'b0;
    end else begin
      done_o <= 1'b0;
      req_d_reg <= cyc_req_i;
      if (!cyc_req_i) begin
        wait_reg <= lat_i;
        gap_reg <= gap_reg + 8'h01;
      end else if (done_o) begin
        gap_reg <= 8'h00;
        wait_reg <= lat_i;
      end else if (wait_reg == 2'h0) begin
        // done only once per unit, a pulse
        done_o <= 1'b1;
        units_o <= units_o + 16'h0001;
        last_bytes_o <= cyc_bytes_i;
      end else begin
        wait_reg <= wait_reg - 2'h1;
      end
      if (cyc_req_i && !req_d_reg) begin
        last_gap_o <= gap_reg;
      end
    end
  end
endmodule

/* File: verif/test_dma_request_and_end_control.sv */
// self-checking bench for the request and end control channel
`timescale 1ns/1ns
`include "drc_defines.vh"
module test_dma_request_and_end_control;
  reg clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h00000000;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg nmi = 1'b0, aerr = 1'b0, srco = 1'b0, dsto = 1'b0, want = 1'b0;
  reg [1:0] lat = 2'h0;
  reg [31:0] rng = 32'h0000001D;
  wire awready, wready, bvalid, arready, rvalid, req_n, done, cyc_req, ce_irq, es_irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] bytes, lbytes;
  wire [15:0] units;
  wire [7:0] gap;
  integer bad_count = 0;
  integer check_count = 0;
  integer k, n;
  reg [65:0] q[$];
  reg [65:0] e;
  reg [15:0] u0;
  reg [7:0] g0;
  always #5 clk_i = ~clk_i;
  drc_channel dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .dma_request_in_n_i(req_n),
    .nmi_i(nmi), .addr_error_i(aerr), .src_overflow_i(srco), .dst_overflow_i(dsto), .cyc_req_o(cyc_req),
    .cyc_write_o(), .cyc_bytes_o(bytes), .cyc_done_i(done), .count_end_irq_o(ce_irq), .escape_end_irq_o(es_irq));
  drc_periph_model periph_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .want_i(want), .lat_i(lat), .cyc_req_i(cyc_req),
    .cyc_bytes_i(bytes), .req_n_o(req_n), .done_o(done), .units_o(units), .last_bytes_o(lbytes), .last_gap_o(gap));
  ////////////////////////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  always @(posedge clk_i) begin
    rng <= xs(rng);
    lat <= rng[1:0];
  end
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== ex) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %0h seen %0h", nm, ex, got);
      end
    end
  endtask
  // read notes are settled by the watcher at the edge that takes the data
  always @(posedge clk_i) begin
    if (rvalid && rready) begin
      e = q.pop_front();
      chk("rdata", e[31:0], rdata & e[63:32]);
      chk("rresp", {30'h0, e[65:64]}, {30'h0, rresp});
    end
    if (bvalid && bready)
      chk("bresp", {30'h0, `DRC_RESP_OKAY}, {30'h0, bresp});
  end
  task wr(input [7:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge clk_i);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
    end
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] x, input [1:0] r);
    begin
      q.push_back({r, m, x});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge clk_i);
        if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
    end
  endtask
  task run(input [31:0] acr, input [31:0] cnt, input [31:0] md);
    begin
      u0 = units;
      wr(`DRC_OFF_MODE, 32'h00000000);
      wr(`DRC_OFF_ACR, acr);
      wr(`DRC_OFF_CNT, cnt);
      wr(`DRC_OFF_MODE, md);
      n = 0;
      while (ce_irq !== 1'b1 && es_irq !== 1'b1 && n < 400) begin
        @(posedge clk_i);
        n = n + 1;
      end
      // an endless count is expected to run out the limit
      chk("run_end", 32'h1, (n < 400) || (cnt == 32'h00000000));
      repeat (4) @(posedge clk_i);
    end
  endtask
  task end_of_test;
    begin
      $display("counts: mismatches %0d checks %0d", bad_count, check_count);
      if (bad_count == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #300000;
    bad_count = bad_count + 1;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    want <= 1'b1;
    @(posedge clk_i);
    rd(`DRC_OFF_MODE, 32'hFFFFFFFF, `DRC_MODE_RST, `DRC_RESP_OKAY);
    rd(`DRC_OFF_ACR, 32'hFFFFFFFF, `DRC_ACR_RST, `DRC_RESP_OKAY);
    rd(`DRC_OFF_CNT, 32'hFFFFFFFF, `DRC_CNT_RST, `DRC_RESP_OKAY);
    rd(`DRC_OFF_BLK, 32'h0000FFFF, 32'h00000001, `DRC_RESP_OKAY);
    rd(8'h10, 32'hFFFFFFFF, 32'h00000000, `DRC_RESP_SLVERR);
    $display("test reset_values done");
    run(32'h00000000, 32'h00000003, 32'h00000091);
    chk("units", 32'h3, units - u0);
    rd(`DRC_OFF_MODE, 32'h0000000F, 32'h00000004, `DRC_RESP_OKAY);
    rd(`DRC_OFF_CNT, 32'hFFFFFFFF, 32'h00000000, `DRC_RESP_OKAY);
    chk("count_irq", 32'h1, ce_irq);
    $display("test count_end done");
    run(32'h00000000, 32'h00000003, 32'h000004A1);
    chk("units", 32'h1, units - u0);
    rd(`DRC_OFF_MODE, 32'h0000000F, 32'h00000008, `DRC_RESP_OKAY);
    chk("escape_irq", 32'h1, es_irq);
    run(32'h00000000, 32'h00000003, 32'h00000491);
    chk("units", 32'h2, units - u0);
    chk("bytes", 32'h1, lbytes);
    $display("test size_error done");
    for (k = 0; k < 2; k = k + 1) begin
      run(32'h00000000, 32'h00000002, 32'h00000091 | (k << 6));
      if (k == 0) g0 = gap;
      else chk("delay_gap", 32'h1, gap - g0);
    end
    $display("test next_request_delay done");
    wr(`DRC_OFF_BLK, 32'h00000002);
    run(32'h00000000, 32'h00000004, 32'h00001291);
    chk("units", 32'h8, units - u0);
    chk("count_irq", 32'h1, ce_irq);
    run(32'h00000001, 32'h00000004, 32'h00000291);
    chk("units", 32'h2, units - u0);
    run(32'h00000000, 32'h00000003, 32'h000002A1);
    chk("units", 32'h2, units - u0);
    chk("escape_irq", 32'h1, es_irq);
    $display("test block_mode done");
    wr(`DRC_OFF_BLK, 32'h00000002);
    run(32'h00000001, 32'h00000008, 32'h00000191);
    chk("units", 32'h2, units - u0);
    rd(`DRC_OFF_MODE, 32'h0000000F, 32'h00000008, `DRC_RESP_OKAY);
    run(32'h00000001, 32'h00000008, 32'h00000191);
    chk("resumed", 32'h2, units - u0);
    $display("test repeat_end done");
    for (k = 0; k < 4; k = k + 1) begin
      wr(`DRC_OFF_BLK, 32'h00000001);
      run(32'h0000000E, 32'h00000000, 32'h00000081);
      chk("running", 32'h1, (units - u0) > 8);
      {dsto, srco, aerr, nmi} <= 4'h1 << k;
      @(posedge clk_i);
      {dsto, srco, aerr, nmi} <= 4'h0;
      repeat (20) @(posedge clk_i);
      rd(`DRC_OFF_MODE, 32'h00008009, (k < 2) ? 32'h00008000 : 32'h00000008, `DRC_RESP_OKAY);
      if (k < 2) begin
        wr(`DRC_OFF_MODE, 32'h00008081);
        repeat (10) @(posedge clk_i);
        u0 = units;
        repeat (20) @(posedge clk_i);
        chk("blocked", u0, units);
        wr(`DRC_OFF_MODE, 32'h00000000);
        wr(`DRC_OFF_MODE, 32'h00000081);
        repeat (20) @(posedge clk_i);
        chk("restart", 32'h1, units != u0);
        wr(`DRC_OFF_MODE, 32'h00000080);
        repeat (10) @(posedge clk_i);
        u0 = units;
        repeat (20) @(posedge clk_i);
        chk("sw_stop", u0, units);
      end
      $display("test forced_stop %0d done", k);
    end
    end_of_test;
  end
endmodule
bind drc_channel drc_channel_props props_u (.clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .nmi_i, .addr_error_i, .cyc_req_o,
  .cyc_bytes_o, .cyc_done_i, .cyc_write_o);
